/* verilog/blink_pkg.sv */
/*
 * Shared constants and state type for the single-line blink command controller.
 * Assumes a 25 MHz free-running clock standing in for the internal oscillator.
 */
package blink_pkg;

    // clock rate, in kHz so that cycle products stay inside 32 bits
    localparam int unsigned CLK_KHZ = 25000;

    // command timing, in microseconds
    localparam int unsigned WINDOW_US = 500;
    localparam int unsigned QUIET_END_US = 1500;
    // least time rounds up, longest time rounds down
    localparam int unsigned WINDOW_CYCLES = (WINDOW_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned QUIET_END_CYCLES = (QUIET_END_US * CLK_KHZ) / 1000;

    // interval measurement, in milliseconds
    localparam int unsigned ON_STEP_MS = 1;
    localparam int unsigned OFF_STEP_MS = 10;
    localparam int unsigned ON_TIMEOUT_MS = 319;
    localparam int unsigned OFF_TIMEOUT_MS = 3190;
    localparam int unsigned MS_CYCLES = CLK_KHZ * ON_STEP_MS;
    localparam logic [8:0] ON_MAX_STEPS = 9'(ON_TIMEOUT_MS / ON_STEP_MS);
    localparam logic [8:0] OFF_MAX_STEPS = 9'(OFF_TIMEOUT_MS / OFF_STEP_MS);
    localparam logic [3:0] SUB_LAST = 4'(OFF_STEP_MS / ON_STEP_MS - 1);
    localparam logic [3:0] OFF_HALF_MS = 4'(OFF_STEP_MS / 2);

    // command codes are the rising-edge counts inside the command window
    localparam logic [2:0] CMD_RUN = 3'h1;
    localparam logic [2:0] CMD_TRAIN_START = 3'h2;
    localparam logic [2:0] CMD_TRAIN_END = 3'h3;
    localparam logic [2:0] CMD_RUN_ONCE = 3'h4;

    localparam int unsigned SEQ_DEPTH = 3;
    localparam logic [1:0] SEQ_FULL = 2'h3;
    localparam logic LED_RESET = 1'b0;

    typedef enum logic [3:0] {
        ST_STANDBY,
        ST_WINDOW,
        ST_QUIET,
        ST_DEFER,
        ST_FOLLOW,
        ST_PLAY_ON,
        ST_PLAY_OFF,
        ST_TRAIN_ARM,
        ST_TRAIN_ON,
        ST_TRAIN_OFF
    } mode_e;

endpackage

/* verilog/blink_ctrl.sv */
/*
 * Mode controller and pulse-count command front end of a single-LED blink driver.
 * Assumes cmd_pulse_in and over_temp_in are plain levels from outside, rst_in is the power-on reset.
 */
// Notes on behaviour
// (R1) reset holds all state at defaults
// (R2) after reset sit in standby, LED off
// (R3) rising edge leaves standby into active modes
// (R4) unprogrammed run copies input onto LED
// (R5) programmed run plays stored intervals
// (R6) run once plays once, then standby
// (R7) run once needs a stored sequence
// (R8) training captures sequence, LED mirrors input
// (R9) over-temperature forces LED off, logic runs
// (R10) command window lasts at least 500 us
// (R11) count rising edges in window as command
// (R12) quiet period ends by 1500 us; host quiet
// (R13) input high at window close: execute after quiet
// (R14) input low: defer until high, except run
// (R15) host holds input high for run
// (R16) on intervals in 1 ms steps, min 1
// (R17) off intervals in 10 ms steps, min 1
// (R18) measurement saturates at 319 ms / 3.19 s
// (R19) one edge run, four edges run once
// (R20) two edges start training
// (R21) three edges end training, store sequence
// (R22) synchronise input, time from local clock
`timescale 1ns/1ps
`default_nettype none

module blink_ctrl #(
    parameter int unsigned WINDOW_CYCLES = blink_pkg::WINDOW_CYCLES,
    parameter int unsigned QUIET_END_CYCLES = blink_pkg::QUIET_END_CYCLES,
    parameter int unsigned MS_CYCLES = blink_pkg::MS_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_pulse_in,
    input wire logic over_temp_in,
    output logic led_out,
    output logic thermal_shutdown_state_out,
    output logic programmed_out,
    output logic active_out
);

////////////////////////////////////////////////////////////////////////////////
// input synchroniser and edge detection

logic sync1_q;
logic sync2_q;
logic prev_q;
wire rise = sync2_q & ~prev_q;
wire level = sync2_q;

always_ff @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        sync1_q <= 1'b0;
        sync2_q <= 1'b0;
        prev_q <= 1'b0;
    end
    else
    begin
        sync1_q <= cmd_pulse_in; // R22
        sync2_q <= sync1_q;
        prev_q <= sync2_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// state and bookkeeping registers

blink_pkg::mode_e state_q, state_d;
logic [15:0] timer_q;
logic [2:0] edges_q;
logic level_close_q;
logic [2:0] pend_q, pend_d;
logic training_q, training_d;
logic off_pend_q, off_pend_d;
logic repeat_q, repeat_d;
logic [1:0] idx_q, idx_d;
logic [1:0] pairs_q, pairs_d;
logic [1:0] cap_q, cap_d;
logic [14:0] pre_q;
logic [3:0] sub_q;
logic [8:0] steps_q;
logic [8:0] on_mem_q [0:blink_pkg::SEQ_DEPTH-1];
logic [8:0] off_mem_q [0:blink_pkg::SEQ_DEPTH-1];
logic restart;
logic wr_on;
logic wr_off;
logic led_q;
logic tsd_q;
logic prog_q;
logic active_q;

wire in_window = (state_q == blink_pkg::ST_WINDOW);
wire in_quiet = (state_q == blink_pkg::ST_QUIET);
wire window_end = in_window && (timer_q == 16'(WINDOW_CYCLES - 1));
wire quiet_end = in_quiet && (timer_q == 16'(QUIET_END_CYCLES - 1));
wire programmed = (pairs_q != 2'h0);

// step timing: 1 ms units for on phases, 10 ms units for off phases
wire off_phase = (state_q == blink_pkg::ST_PLAY_OFF) || (state_q == blink_pkg::ST_TRAIN_OFF);
wire ms_tick = (pre_q == 15'(MS_CYCLES - 1));
wire unit_tick = ms_tick && (!off_phase || (sub_q == blink_pkg::SUB_LAST));
wire [8:0] step_max = off_phase ? blink_pkg::OFF_MAX_STEPS : blink_pkg::ON_MAX_STEPS;
wire sat_now = unit_tick && (steps_q == step_max - 9'h001);
wire [8:0] rec_val = sat_now ? step_max : ((steps_q == 9'h000) ? 9'h001 : steps_q);
wire off_ok = (steps_q != 9'h000) || (sub_q >= blink_pkg::OFF_HALF_MS);

// playback compare against the current entry
wire [8:0] cur_on = on_mem_q[idx_q];
wire [8:0] cur_off = off_mem_q[idx_q];
wire on_done = unit_tick && (steps_q + 9'h001 >= cur_on);
wire off_done = unit_tick && (steps_q + 9'h001 >= cur_off);
wire last_entry = (idx_q == pairs_q - 2'h1);

// command execution target, shared by the immediate and deferred paths
wire [2:0] cmd_sel = (state_q == blink_pkg::ST_DEFER) ? pend_q : edges_q;
wire deferred = (state_q == blink_pkg::ST_DEFER);
blink_pkg::mode_e exec_state;
always_comb
begin
    case (cmd_sel)
        blink_pkg::CMD_RUN: exec_state = programmed ? blink_pkg::ST_PLAY_ON : blink_pkg::ST_FOLLOW; // R4 R5 R19
        blink_pkg::CMD_TRAIN_START: exec_state = deferred ? blink_pkg::ST_TRAIN_ON : blink_pkg::ST_TRAIN_ARM; // R20
        blink_pkg::CMD_RUN_ONCE: exec_state = programmed ? blink_pkg::ST_PLAY_ON : blink_pkg::ST_STANDBY; // R7
        default: exec_state = blink_pkg::ST_STANDBY;
    endcase
end
wire exec_clear = (cmd_sel == blink_pkg::CMD_TRAIN_START);

////////////////////////////////////////////////////////////////////////////////
// mode sequencing

always_comb
begin
    state_d = state_q;
    pend_d = pend_q;
    training_d = training_q;
    off_pend_d = off_pend_q;
    repeat_d = repeat_q;
    idx_d = idx_q;
    pairs_d = pairs_q;
    cap_d = cap_q;
    restart = 1'b0;
    wr_on = 1'b0;
    wr_off = 1'b0;
    case (state_q)
        blink_pkg::ST_STANDBY:
            if (rise)
            begin
                state_d = blink_pkg::ST_WINDOW; // R3
                training_d = 1'b0;
                off_pend_d = 1'b0;
            end
        blink_pkg::ST_WINDOW:
            if (window_end)
                state_d = blink_pkg::ST_QUIET;
        blink_pkg::ST_QUIET:
            if (quiet_end && training_q)
            begin
                // the window was opened by a pulse during capture
                if (edges_q == blink_pkg::CMD_TRAIN_END)
                begin
                    pairs_d = cap_q + 2'(off_pend_q); // R21
                    state_d = blink_pkg::ST_STANDBY;
                end
                else if (edges_q == blink_pkg::CMD_RUN && off_pend_q && cap_q == blink_pkg::SEQ_FULL - 2'h1)
                begin
                    pairs_d = blink_pkg::SEQ_FULL;
                    state_d = blink_pkg::ST_STANDBY;
                end
                else if (edges_q == blink_pkg::CMD_RUN)
                begin
                    cap_d = cap_q + 2'(off_pend_q);
                    state_d = blink_pkg::ST_TRAIN_ON;
                end
                else
                    state_d = blink_pkg::ST_STANDBY;
            end
            else if (quiet_end)
            begin
                if (level_close_q)
                begin
                    state_d = exec_state; // R13
                    restart = 1'b1;
                    idx_d = 2'h0;
                    repeat_d = (edges_q == blink_pkg::CMD_RUN);
                    if (exec_clear)
                    begin
                        pairs_d = 2'h0;
                        cap_d = 2'h0;
                    end
                end
                else if (edges_q == blink_pkg::CMD_RUN)
                    state_d = blink_pkg::ST_STANDBY; // R14
                else
                begin
                    state_d = blink_pkg::ST_DEFER; // R14
                    pend_d = edges_q;
                end
            end
        blink_pkg::ST_DEFER:
            if (rise)
            begin
                state_d = exec_state;
                restart = 1'b1;
                idx_d = 2'h0;
                repeat_d = 1'b0;
                if (exec_clear)
                begin
                    pairs_d = 2'h0;
                    cap_d = 2'h0;
                end
            end
        blink_pkg::ST_FOLLOW:
            if (!level)
                state_d = blink_pkg::ST_STANDBY;
        blink_pkg::ST_PLAY_ON:
            if (!level)
                state_d = blink_pkg::ST_STANDBY;
            else if (on_done)
            begin
                state_d = blink_pkg::ST_PLAY_OFF; // R5
                restart = 1'b1;
            end
        blink_pkg::ST_PLAY_OFF:
            if (!level)
                state_d = blink_pkg::ST_STANDBY;
            else if (off_done && last_entry && !repeat_q)
                state_d = blink_pkg::ST_STANDBY; // R6
            else if (off_done)
            begin
                state_d = blink_pkg::ST_PLAY_ON;
                restart = 1'b1;
                idx_d = last_entry ? 2'h0 : idx_q + 2'h1;
            end
        blink_pkg::ST_TRAIN_ARM:
            if (rise)
            begin
                state_d = blink_pkg::ST_WINDOW; // R8
                training_d = 1'b1;
                off_pend_d = 1'b0;
                restart = 1'b1;
            end
        blink_pkg::ST_TRAIN_ON:
            if (!level || sat_now)
            begin
                wr_on = 1'b1; // R16 R18
                state_d = blink_pkg::ST_TRAIN_OFF;
                restart = 1'b1;
            end
        blink_pkg::ST_TRAIN_OFF:
            if (sat_now)
            begin
                wr_off = 1'b1; // R18
                pairs_d = cap_q + 2'h1;
                state_d = blink_pkg::ST_STANDBY;
            end
            else if (rise)
            begin
                wr_off = off_ok; // R17
                off_pend_d = off_ok;
                training_d = 1'b1;
                state_d = blink_pkg::ST_WINDOW;
                restart = 1'b1;
            end
        default:
            state_d = blink_pkg::ST_STANDBY;
    endcase
end

always_ff @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        state_q <= blink_pkg::ST_STANDBY; // R1 R2
        pend_q <= 3'h0;
        training_q <= 1'b0;
        off_pend_q <= 1'b0;
        repeat_q <= 1'b0;
        idx_q <= 2'h0;
        pairs_q <= 2'h0;
        cap_q <= 2'h0;
    end
    else
    begin
        state_q <= state_d;
        pend_q <= pend_d;
        training_q <= training_d;
        off_pend_q <= off_pend_d;
        repeat_q <= repeat_d;
        idx_q <= idx_d;
        pairs_q <= pairs_d;
        cap_q <= cap_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// command window timer and edge counter

wire [15:0] timer_d = (in_window || in_quiet) ? timer_q + 16'h0001 : 16'h0000;
wire opening = (state_d == blink_pkg::ST_WINDOW) && !in_window;
// saturating count keeps stray bursts from wrapping onto a valid code
wire [2:0] edges_d = opening ? 3'h1 : ((in_window && rise && edges_q != 3'h7) ? edges_q + 3'h1 : edges_q);

always_ff @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        timer_q <= 16'h0000;
        edges_q <= 3'h0;
        level_close_q <= 1'b0;
    end
    else
    begin
        timer_q <= timer_d; // R10 R12
        edges_q <= edges_d; // R11
        level_close_q <= window_end ? level : level_close_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// interval step timer

wire [14:0] pre_d = (restart || ms_tick) ? 15'h0000 : pre_q + 15'h0001;
wire [3:0] sub_d = restart ? 4'h0 : (ms_tick ? ((sub_q == blink_pkg::SUB_LAST) ? 4'h0 : sub_q + 4'h1) : sub_q);
wire [8:0] steps_d = restart ? 9'h000 : ((unit_tick && steps_q != step_max) ? steps_q + 9'h001 : steps_q);

always_ff @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        pre_q <= 15'h0000;
        sub_q <= 4'h0;
        steps_q <= 9'h000;
    end
    else
    begin
        pre_q <= pre_d;
        sub_q <= sub_d;
        steps_q <= steps_d; // R16 R17
    end
end

////////////////////////////////////////////////////////////////////////////////
// sequence memory, one on and one off interval per entry

genvar gi;
generate
    for (gi = 0; gi < blink_pkg::SEQ_DEPTH; gi++)
    begin : g_entry
        wire hit = (cap_q == 2'(gi));
        always_ff @(posedge clk_in or posedge rst_in)
        begin
            if (rst_in)
            begin
                on_mem_q[gi] <= 9'h000;
                off_mem_q[gi] <= 9'h000;
            end
            else
            begin
                on_mem_q[gi] <= (wr_on && hit) ? rec_val : on_mem_q[gi];
                off_mem_q[gi] <= (wr_off && hit) ? rec_val : off_mem_q[gi];
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// outputs

wire mirror = (state_q == blink_pkg::ST_FOLLOW) || (state_q == blink_pkg::ST_TRAIN_ARM) ||
    (state_q == blink_pkg::ST_TRAIN_ON) || ((in_window || in_quiet) && training_q);
wire led_want = (mirror && level) || (state_q == blink_pkg::ST_PLAY_ON);
// thermal shutdown only gates the driver; the sequencer keeps its place
wire led_d = led_want && !over_temp_in;

always_ff @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        led_q <= blink_pkg::LED_RESET;
        tsd_q <= 1'b0;
        prog_q <= 1'b0;
        active_q <= 1'b0;
    end
    else
    begin
        led_q <= led_d; // R4 R8 R9
        tsd_q <= over_temp_in; // R9
        prog_q <= programmed;
        active_q <= (state_q != blink_pkg::ST_STANDBY);
    end
end

assign led_out = led_q;
assign thermal_shutdown_state_out = tsd_q;
assign programmed_out = prog_q;
assign active_out = active_q;

////////////////////////////////////////////////////////////////////////////////
// checks

a_standby_dark: assert property (@(posedge clk_in) disable iff (rst_in) // R2
    (state_q == blink_pkg::ST_STANDBY) |=> !led_q)
    else $error("led lit out of standby state");

a_wake_on_edge: assert property (@(posedge clk_in) disable iff (rst_in) // R3
    (state_q == blink_pkg::ST_STANDBY && rise) |=> (state_q == blink_pkg::ST_WINDOW && edges_q == 3'h1))
    else $error("rising edge did not open the command window");

a_follow_copy: assert property (@(posedge clk_in) disable iff (rst_in) // R4
    (state_q == blink_pkg::ST_FOLLOW && !over_temp_in) |=> (led_q == $past(sync2_q)))
    else $error("led does not follow input in run");

a_thermal_dark: assert property (@(posedge clk_in) disable iff (rst_in) // R9
    over_temp_in |=> (!led_q && tsd_q))
    else $error("led lit during thermal shutdown");

a_window_hold: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    (in_window && timer_q < 16'(WINDOW_CYCLES - 1)) |=> in_window)
    else $error("command window closed early");

a_quiet_bound: assert property (@(posedge clk_in) disable iff (rst_in) // R12
    in_quiet |-> (timer_q <= 16'(QUIET_END_CYCLES - 1)))
    else $error("quiet period overran its end");

a_defer_low: assert property (@(posedge clk_in) disable iff (rst_in) // R14
    (quiet_end && !training_q && !level_close_q && edges_q >= blink_pkg::CMD_TRAIN_START &&
    edges_q <= blink_pkg::CMD_RUN_ONCE) |=> (state_q == blink_pkg::ST_DEFER && pend_q == $past(edges_q)))
    else $error("low input did not defer the command");

a_run_once_empty: assert property (@(posedge clk_in) disable iff (rst_in) // R7
    (quiet_end && !training_q && level_close_q && edges_q == blink_pkg::CMD_RUN_ONCE && !programmed)
    |=> (state_q == blink_pkg::ST_STANDBY))
    else $error("run once played with nothing stored");

a_once_ends: assert property (@(posedge clk_in) disable iff (rst_in) // R6
    (state_q == blink_pkg::ST_PLAY_OFF && off_done && last_entry && !repeat_q) |=>
    (state_q == blink_pkg::ST_STANDBY))
    else $error("run once did not return to standby");

a_step_sat: assert property (@(posedge clk_in) disable iff (rst_in) // R18
    (steps_q == step_max && !restart && state_q == $past(state_q)) |=> (steps_q == $past(steps_q)))
    else $error("interval counter passed its timeout");

endmodule

`default_nettype wire

/* tb/blink_host_model.sv */
/*
 * Host side of the single control line: makes level changes and counted pulse bursts.
 * Assumes the bench calls its tasks one at a time and that the line is sampled on clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module blink_host_model (
    input wire logic clk_in,
    output logic cmd_pulse_out
);

    initial cmd_pulse_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // set the line at an edge, then hold it for the given number of cycles
    task automatic drive(input logic level, input int cycles);
        @(posedge clk_in);
        cmd_pulse_out <= level;
        repeat (cycles - 1) @(posedge clk_in);
    endtask

    // all rises packed into the first cycles of the window, none left for the quiet time
    task automatic burst(input int count, input logic keep_high);
        for (int i = 0; i < count; i++)
        begin
            drive(1'b1, 2);
            // run needs the line left high after the window
            if (i < count - 1 || !keep_high)
            begin
                drive(1'b0, 2);
            end
        end
    endtask

endmodule

`default_nettype wire

/* tb/led_blink_command_controller_tb.sv */
/*
 * Self-checking bench for the blink command controller, with shortened window and step counts.
 * Assumes the host model in blink_host_model.sv and the package blink_pkg compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module led_blink_command_controller_tb;

    localparam int WIN = 20;
    localparam int QEND = 60;
    localparam int MSC = 40;
    // margin past quiet end covers sync and output flops
    localparam int EXEC = QEND + 8;

    logic clk_in;
    logic rst_in;
    logic over_temp_in;
    logic cmd_line;
    logic led_out;
    logic tsd_out;
    logic programmed_out;
    logic active_out;
    int miscompares;
    int num_checks;

    blink_ctrl #(
        .WINDOW_CYCLES(WIN),
        .QUIET_END_CYCLES(QEND),
        .MS_CYCLES(MSC)
    ) uut (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cmd_pulse_in(cmd_line),
        .over_temp_in(over_temp_in),
        .led_out(led_out),
        .thermal_shutdown_state_out(tsd_out),
        .programmed_out(programmed_out),
        .active_out(active_out)
    );

    blink_host_model host (
        .clk_in(clk_in),
        .cmd_pulse_out(cmd_line)
    );

    initial clk_in = 1'b0;
    always #20 clk_in = ~clk_in;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic seen, input logic expected, input string what);
        num_checks++;
        if (seen !== expected)
        begin
            miscompares++;
            $display("mismatch at %0t: %s seen %b expected %b", $time, what, seen, expected);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // sample half a cycle after the last edge so outputs have settled
    task automatic settle(input int cycles);
        repeat (cycles) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task automatic wait_active(input logic level, input int bound);
        int n;
        n = 0;
        while (active_out !== level && n < bound)
        begin
            @(negedge clk_in);
            n++;
        end
        check(active_out, level, "active level reached");
        if (active_out !== level)
        begin
            give_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        settle(2);
        check(led_out, 1'b0, "led in reset");
        check(active_out, 1'b0, "active in reset");
        check(programmed_out, 1'b0, "programmed in reset");
        @(posedge clk_in);
        rst_in <= 1'b0;
        settle(3);
        check(active_out, 1'b0, "standby after reset");
        check(led_out, 1'b0, "led off after reset");
        $display("test reset done");
    endtask

    task automatic test_run_plain();
        host.burst(1, 1'b1);
        settle(WIN);
        check(active_out, 1'b1, "active after wake");
        check(led_out, 1'b0, "led off in window");
        settle(QEND - WIN - 30);
        check(led_out, 1'b0, "led off in quiet");
        settle(34);
        check(led_out, 1'b1, "led copies high line");
        host.drive(1'b0, 1);
        settle(5);
        check(led_out, 1'b0, "led copies low line");
        wait_active(1'b0, 10);
        $display("test run_plain done");
    endtask

    task automatic test_run_low();
        host.burst(1, 1'b0);
        settle(EXEC);
        check(active_out, 1'b0, "run with low line dropped");
        check(led_out, 1'b0, "led off after dropped run");
        $display("test run_low done");
    endtask

    task automatic test_once_empty();
        host.burst(4, 1'b1);
        settle(EXEC);
        check(led_out, 1'b0, "run once with nothing stored");
        check(active_out, 1'b0, "standby after empty run once");
        host.drive(1'b0, 1);
        $display("test once_empty done");
    endtask

    task automatic test_train();
        host.burst(2, 1'b1);
        settle(EXEC);
        check(active_out, 1'b1, "training entered");
        check(led_out, 1'b1, "training mirrors high");
        host.drive(1'b0, 1);
        settle(4);
        check(led_out, 1'b0, "training mirrors low");
        // 3.5 ms on, 25 ms off: half a step of margin, stored as 3 and 2 steps
        host.drive(1'b1, 3 * MSC + MSC / 2);
        host.drive(1'b0, 25 * MSC);
        host.burst(3, 1'b1);
        settle(EXEC);
        check(programmed_out, 1'b1, "sequence stored");
        check(active_out, 1'b0, "standby after training end");
        host.drive(1'b0, 1);
        $display("test train done");
    endtask

    task automatic test_run_prog();
        host.burst(1, 1'b1);
        settle(EXEC);
        check(led_out, 1'b1, "stored on phase");
        settle(100);
        check(led_out, 1'b1, "on lasts three steps");
        settle(26);
        check(led_out, 1'b0, "on ends after three steps");
        settle(734);
        check(led_out, 1'b0, "off lasts two steps");
        settle(100);
        check(led_out, 1'b1, "sequence repeats");
        @(posedge clk_in);
        over_temp_in <= 1'b1;
        settle(3);
        check(led_out, 1'b0, "led off in shutdown");
        check(tsd_out, 1'b1, "shutdown shown");
        check(active_out, 1'b1, "logic runs in shutdown");
        @(posedge clk_in);
        over_temp_in <= 1'b0;
        settle(3);
        check(tsd_out, 1'b0, "shutdown cleared");
        host.drive(1'b0, 1);
        wait_active(1'b0, 10);
        check(led_out, 1'b0, "led off after run");
        $display("test run_prog done");
    endtask

    task automatic test_once_deferred();
        host.burst(4, 1'b0);
        settle(EXEC);
        check(active_out, 1'b1, "run once waits for high");
        check(led_out, 1'b0, "nothing played while low");
        host.drive(1'b1, 1);
        settle(40);
        check(led_out, 1'b1, "deferred run once plays");
        settle(200);
        check(led_out, 1'b0, "off phase of run once");
        settle(800);
        check(active_out, 1'b0, "standby after one pass");
        check(led_out, 1'b0, "no repeat after one pass");
        host.drive(1'b0, 1);
        $display("test once_deferred done");
    endtask

    task automatic test_reset_again();
        @(posedge clk_in);
        rst_in <= 1'b1;
        settle(2);
        check(programmed_out, 1'b0, "memory cleared by reset");
        @(posedge clk_in);
        rst_in <= 1'b0;
        settle(3);
        check(active_out, 1'b0, "standby after second reset");
        $display("test reset_again done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_in = 1'b1;
        over_temp_in = 1'b0;
        miscompares = 0;
        num_checks = 0;
        repeat (5) @(posedge clk_in);
        test_reset();
        test_run_plain();
        test_run_low();
        test_once_empty();
        test_train();
        test_run_prog();
        test_once_deferred();
        test_reset_again();
        give_verdict();
    end

endmodule

`default_nettype wire
